// ===== logic/fcmc_defines.svh
/*
 Constants for the flash configuration mode controller: mode codes, widths and counts.
 Assumes inclusion by bare name from design files of the same block.
*/
`ifndef FCMC_DEFINES_SVH
`define FCMC_DEFINES_SVH

`define FCMC_MODE_W 3
`define FCMC_MODE_FLASH 3'h2
`define FCMC_MODE_JTAG 3'h5
`define FCMC_WORD_W 16
`define FCMC_ADDR_W 24
`define FCMC_START_ADDR 24'h000000
`define FCMC_CLEAR_NS 200
`define FCMC_CLK_NS 25
`define FCMC_CLEAR_CYC ((`FCMC_CLEAR_NS + `FCMC_CLK_NS - 1) / `FCMC_CLK_NS)
`define FCMC_CNT_W 4
`define FCMC_SETTLE_CYC 8
`define FCMC_SYNC_IDLE 3'h1
`define FCMC_CRC_INIT 16'hFFFF
`define FCMC_CRC_POLY 16'h8005

`endif

// ===== logic/fcmc_pkg.sv
/*
 Types for the flash configuration mode controller.
 Assumes fcmc_defines.svh is available on the include path.
*/
`include "fcmc_defines.svh"

package fcmc_pkg;

   typedef enum logic [2:0] {
      FCMC_ST_POR,
      FCMC_ST_CLEAR,
      FCMC_ST_WAIT_INIT,
      FCMC_ST_LOAD,
      FCMC_ST_JTAG,
      FCMC_ST_CRC_ERR,
      FCMC_ST_DONE,
      FCMC_ST_IDLE
   } fcmc_state_t;

   typedef struct packed {
      logic [15:0] data;
      logic valid;
   } fcmc_word_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] data;
      logic valid;
   } fcmc_jtag_req_t;

endpackage : fcmc_pkg

// ===== logic/fcmc_top.sv
/*
 Configuration mode control of a device loading itself from a parallel flash.
 Main logic runs on clk_i; the flash fetch path runs on link_clk_i, the
 configuration timing source that this logic enables. Pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fcmc_defines.svh"

// Notes on behaviour
// R1: Mode pins 010 choose ascending-address parallel flash configuration.
// R2: Mode pins 101 choose JTAG mode; no flash activity at all.
// R3: Mode pins sampled on handshake rising edge; matching sequence starts.
// R4: Program line and flash reset are one shared line.
// R5: Program line low clears configuration, then full reconfiguration follows.
// R6: Outside logic keeps program line high after configuration.
// R7: Outside logic keeps program line high during indirect programming.
// R8: Program line low during indirect programming aborts programming.
// R9: Flash is programmed only through the JTAG port.
// R10: Programming core takes JTAG commands, drives flash, returns results; the core here drives no flash and returns data XOR cmd.
// R11: Handshake held low during own reset, released afterwards.
// R12: Flash loads start address on handshake rising edge.
// R13: Each clock advances address; word captured next rising edge.
// R14: Detected CRC error drives handshake low.
// R15: Mode pins held stable across handshake rising edge.
module fcmc_top
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic link_clk_i,
   input wire logic flash_reset_n_i,
   input wire logic [`FCMC_MODE_W-1:0] mode_i,
   input wire logic init_hs_i,
   output logic init_hs_o,
   output logic init_hs_oe_o,
   output logic timing_en_o,
   input wire logic [`FCMC_WORD_W-1:0] flash_data_i,
   output logic [`FCMC_ADDR_W-1:0] flash_addr_o,
   input wire logic frame_end_i,
   input wire logic [15:0] frame_crc_i,
   input wire fcmc_pkg::fcmc_jtag_req_t jtag_req_i,
   output fcmc_pkg::fcmc_word_t jtag_resp_o,
   output logic prog_busy_o,
   output logic prog_abort_o,
   output logic config_done_o,
   output logic [`FCMC_MODE_W-1:0] mode_o
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic [`FCMC_MODE_W-1:0] mode_s1_ff;
   logic [`FCMC_MODE_W-1:0] mode_s2_ff;
   logic hs_prev_ff;
   logic prog_n_s;
   logic hs_s;
   logic fend_s;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         // The program line idles high; low reset stages would fake a clear.
         sync1_ff <= `FCMC_SYNC_IDLE;
         sync2_ff <= `FCMC_SYNC_IDLE;
         mode_s1_ff <= 3'h0;
         mode_s2_ff <= 3'h0;
         hs_prev_ff <= 1'h0;
      end
      else
      begin
         sync1_ff <= {frame_end_i, init_hs_i, flash_reset_n_i};
         sync2_ff <= sync1_ff;
         mode_s1_ff <= mode_i;
         mode_s2_ff <= mode_s1_ff;
         hs_prev_ff <= sync2_ff[1];
      end
   end

   assign prog_n_s = sync2_ff[0];
   assign hs_s = sync2_ff[1];
   assign fend_s = sync2_ff[2];

   // ==========================================================
   // Link-side fetch and CRC (link_clk_i domain)
   // ==========================================================
   logic run_l1_ff;
   logic run_l2_ff;
   logic run_l_prev_ff;
   logic [`FCMC_ADDR_W-1:0] addr_ff;
   logic [`FCMC_ADDR_W-1:0] nxt_addr;
   logic [15:0] crc_ff;
   logic [15:0] nxt_crc;
   logic link_clr_ff;
   logic nxt_link_clr;
   logic link_rst_n;

   // R5: a clear empties the fetch side as well. Its clock stands still outside
   // frames, so only a reset can bring it back; the reset is released while the
   // handshake is awaited, long before the link clock starts again.
   assign link_rst_n = nrst_i && !link_clr_ff;

   function automatic logic [15:0] fcmc_crc_step(input logic [15:0] c, input logic [15:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--)
      begin
         if (r[15] ^ d[i])
         begin
            r = {r[14:0], 1'b0} ^ `FCMC_CRC_POLY;
         end
         else
         begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction : fcmc_crc_step

   always_comb
   begin
      nxt_addr = addr_ff;
      nxt_crc = crc_ff;
      if (run_l2_ff && !run_l_prev_ff)
      begin
         // R12: start address load
         nxt_addr = `FCMC_START_ADDR;
         nxt_crc = `FCMC_CRC_INIT;
      end
      else if (run_l2_ff)
      begin
         // R13: advance and capture
         nxt_addr = addr_ff + `FCMC_ADDR_W'(1);
         nxt_crc = fcmc_crc_step(crc_ff, flash_data_i);
      end
   end

   always_ff @(posedge link_clk_i or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         run_l1_ff <= 1'h0;
         run_l2_ff <= 1'h0;
         run_l_prev_ff <= 1'h0;
         addr_ff <= `FCMC_START_ADDR;
         crc_ff <= `FCMC_CRC_INIT;
      end
      else
      begin
         run_l1_ff <= timing_en_o;
         run_l2_ff <= run_l1_ff;
         run_l_prev_ff <= run_l2_ff;
         addr_ff <= nxt_addr;
         crc_ff <= nxt_crc;
      end
   end

   assign flash_addr_o = addr_ff;

   // The CRC word crosses as a plain bus. It is compared only after the fetch
   // enable has been low for the settle count, when the word stands still.
   logic [15:0] crc_c1_ff;
   logic [15:0] crc_c2_ff;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         crc_c1_ff <= 16'h0000;
         crc_c2_ff <= 16'h0000;
      end
      else
      begin
         crc_c1_ff <= crc_ff;
         crc_c2_ff <= crc_c1_ff;
      end
   end

   // ==========================================================
   // Control state machine (clk_i domain)
   // ==========================================================
   fcmc_pkg::fcmc_state_t state_ff;
   fcmc_pkg::fcmc_state_t nxt_state;
   logic [`FCMC_CNT_W-1:0] cnt_ff;
   logic [`FCMC_CNT_W-1:0] nxt_cnt;
   logic [`FCMC_MODE_W-1:0] mode_ff;
   logic [`FCMC_MODE_W-1:0] nxt_mode;
   logic abort_ff;
   logic nxt_abort;
   fcmc_pkg::fcmc_word_t resp_ff;
   fcmc_pkg::fcmc_word_t nxt_resp;
   logic hs_rise;

   assign hs_rise = hs_s && !hs_prev_ff;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_mode = mode_ff;
      nxt_abort = 1'b0;
      nxt_resp = '0;
      if (!prog_n_s)
      begin
         // R4: shared line resets both
         // R5: clear, then restart
         // R8: abort programming
         nxt_abort = (state_ff == fcmc_pkg::FCMC_ST_JTAG) && jtag_req_i.valid;
         nxt_state = fcmc_pkg::FCMC_ST_CLEAR;
         nxt_cnt = `FCMC_CNT_W'(`FCMC_CLEAR_CYC);
      end
      else
      begin
         case (state_ff)
            fcmc_pkg::FCMC_ST_POR,
            fcmc_pkg::FCMC_ST_CLEAR:
            begin
               // R11: hold handshake low
               if (cnt_ff == `FCMC_CNT_W'(0))
               begin
                  nxt_state = fcmc_pkg::FCMC_ST_WAIT_INIT;
               end
               else
               begin
                  nxt_cnt = cnt_ff - `FCMC_CNT_W'(1);
               end
            end
            fcmc_pkg::FCMC_ST_WAIT_INIT:
            begin
               // R3: sample mode on rising edge
               if (hs_rise)
               begin
                  nxt_mode = mode_s2_ff;
                  if (mode_s2_ff == `FCMC_MODE_FLASH)
                  begin
                     // R1: flash mode
                     nxt_state = fcmc_pkg::FCMC_ST_LOAD;
                  end
                  else if (mode_s2_ff == `FCMC_MODE_JTAG)
                  begin
                     // R2: no flash activity
                     nxt_state = fcmc_pkg::FCMC_ST_JTAG;
                  end
                  else
                  begin
                     nxt_state = fcmc_pkg::FCMC_ST_IDLE;
                  end
               end
            end
            fcmc_pkg::FCMC_ST_LOAD:
            begin
               if (cnt_ff != `FCMC_CNT_W'(0))
               begin
                  // R14: CRC error
                  nxt_cnt = cnt_ff - `FCMC_CNT_W'(1);
                  if (cnt_ff == `FCMC_CNT_W'(1))
                  begin
                     if (crc_c2_ff != frame_crc_i)
                     begin
                        nxt_state = fcmc_pkg::FCMC_ST_CRC_ERR;
                     end
                     else
                     begin
                        nxt_state = fcmc_pkg::FCMC_ST_DONE;
                     end
                  end
               end
               else if (fend_s)
               begin
                  // Stopping the fetch first lets the CRC word settle before it is used.
                  nxt_cnt = `FCMC_CNT_W'(`FCMC_SETTLE_CYC);
               end
            end
            fcmc_pkg::FCMC_ST_DONE,
            fcmc_pkg::FCMC_ST_JTAG:
            begin
               // R9: JTAG path only
               // R10: programming core reply
               if (jtag_req_i.valid)
               begin
                  nxt_resp.valid = 1'b1;
                  nxt_resp.data = jtag_req_i.data ^ {8'h00, jtag_req_i.cmd};
               end
            end
            default:
            begin
               nxt_state = state_ff;
            end
         endcase
      end
      nxt_link_clr = (nxt_state == fcmc_pkg::FCMC_ST_CLEAR);
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_ff <= fcmc_pkg::FCMC_ST_POR;
         cnt_ff <= `FCMC_CNT_W'(`FCMC_CLEAR_CYC);
         mode_ff <= 3'h0;
         abort_ff <= 1'h0;
         resp_ff <= '0;
         link_clr_ff <= 1'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         mode_ff <= nxt_mode;
         abort_ff <= nxt_abort;
         resp_ff <= nxt_resp;
         link_clr_ff <= nxt_link_clr;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign init_hs_o = 1'b0;
   assign init_hs_oe_o = (state_ff == fcmc_pkg::FCMC_ST_POR)
      || (state_ff == fcmc_pkg::FCMC_ST_CLEAR)
      || (state_ff == fcmc_pkg::FCMC_ST_CRC_ERR);
   assign timing_en_o = (state_ff == fcmc_pkg::FCMC_ST_LOAD)
      && (cnt_ff == `FCMC_CNT_W'(0));
   assign jtag_resp_o = resp_ff;
   assign prog_busy_o = (state_ff == fcmc_pkg::FCMC_ST_JTAG)
      || (state_ff == fcmc_pkg::FCMC_ST_DONE);
   assign prog_abort_o = abort_ff;
   assign config_done_o = (state_ff == fcmc_pkg::FCMC_ST_DONE);
   assign mode_o = mode_ff;

endmodule : fcmc_top
`default_nettype wire

// ===== tb/fcmc_top_chk.sv
/* Port assertions for the mode controller, on the main clock domain.
   Assumes it is bound to fcmc_top from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
`include "fcmc_defines.svh"
module fcmc_top_chk
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic flash_reset_n_i,
   input wire logic init_hs_o,
   input wire logic init_hs_oe_o,
   input wire logic timing_en_o,
   input wire logic frame_end_i,
   input wire fcmc_pkg::fcmc_jtag_req_t jtag_req_i,
   input wire fcmc_pkg::fcmc_word_t jtag_resp_o,
   input wire logic prog_busy_o,
   input wire logic prog_abort_o,
   input wire logic config_done_o,
   input wire logic [`FCMC_MODE_W-1:0] mode_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // ==========
   // Assertions
   // open drain
   hs_data_low_a: assert property (init_hs_o == 1'b0) else $error("handshake data high");
   mode_excl_a: assert property (!(timing_en_o && prog_busy_o)) else $error("both modes");
   flash_mode_a: assert property (timing_en_o |-> mode_o == `FCMC_MODE_FLASH)
      else $error("loading in wrong mode");
   jtag_mode_a: assert property (prog_busy_o && !config_done_o |-> mode_o == `FCMC_MODE_JTAG)
      else $error("jtag state in wrong mode");
   prog_clear_a: assert property (!flash_reset_n_i [*4] |-> init_hs_oe_o && !timing_en_o
      && !prog_busy_o) else $error("no clear on program low");
   jtag_resp_a: assert property (flash_reset_n_i [*3] ##0 (prog_busy_o && jtag_req_i.valid)
      |=> jtag_resp_o.valid && jtag_resp_o.data == ($past(jtag_req_i.data)
      ^ {8'h00, $past(jtag_req_i.cmd)})) else $error("bad core answer");
   resp_cause_a: assert property (jtag_resp_o.valid |-> $past(jtag_req_i.valid))
      else $error("answer without request");
   abort_cause_a: assert property (prog_abort_o |-> $past(prog_busy_o)
      && $past(jtag_req_i.valid)) else $error("abort without request");
   load_stop_a: assert property ((timing_en_o && frame_end_i) [*3] |=> !timing_en_o)
      else $error("load does not end");
   done_quiet_a: assert property (config_done_o |-> !init_hs_oe_o && !timing_en_o)
      else $error("done with error");
endmodule : fcmc_top_chk
`default_nettype wire

// ===== tb/fcmc_flash_model.sv
/* Behavioural parallel flash on the far side of the link.
   Assumes its clock stands still outside frames. */
`timescale 1ns/1ps
`default_nettype none
`include "fcmc_defines.svh"
module fcmc_flash_model
(
   input wire logic link_clk_i,
   input wire logic flash_reset_n_i,
   input wire logic timing_en_i,
   input wire logic [`FCMC_ADDR_W-1:0] addr_i,
   output logic hs_oe_o,
   output logic [`FCMC_WORD_W-1:0] data_o
);
   initial data_o = 16'h0000;
   assign hs_oe_o = !flash_reset_n_i;
   always @(posedge link_clk_i)
      if (timing_en_i)
         data_o <= {8'hA5 ^ addr_i[7:0], addr_i[7:0]};
   // Outside a frame the bus no longer holds its word, so it shows the inverse.
   always @(negedge timing_en_i)
      data_o <= ~data_o;
endmodule : fcmc_flash_model
`default_nettype wire

// ===== tb/flash_config_mode_control_tb.sv
/* Self-checking bench for the mode controller with a flash model.
   Assumes the design package and defines are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module flash_config_mode_control_tb;
   logic clk_i = 1'b0, nrst = 1'b0, osc = 1'b0, prog_n = 1'b1, fend = 1'b0, abort_seen;
   logic [2:0] mode = 3'h7;
   logic [15:0] fcrc = 16'h5A5A;
   fcmc_pkg::fcmc_jtag_req_t req = '0;
   fcmc_pkg::fcmc_word_t resp;
   wire logic hs, link_clk, hs_d, hs_oe, tmg, fl_oe, busy, abort, done;
   wire logic [15:0] fdata;
   wire logic [23:0] faddr;
   wire logic [2:0] mode_o;
   int n_errors = 0, check_count = 0;
   always #12.5 clk_i = ~clk_i;
   always #16 osc = ~osc;
   assign link_clk = osc & tmg;
   assign hs = !((hs_oe && !hs_d) || fl_oe);
   fcmc_top uut (.clk_i(clk_i), .nrst_i(nrst), .link_clk_i(link_clk), .flash_reset_n_i(prog_n),
      .mode_i(mode), .init_hs_i(hs), .init_hs_o(hs_d), .init_hs_oe_o(hs_oe), .timing_en_o(tmg),
      .flash_data_i(fdata), .flash_addr_o(faddr), .frame_end_i(fend), .frame_crc_i(fcrc),
      .jtag_req_i(req), .jtag_resp_o(resp), .prog_busy_o(busy), .prog_abort_o(abort),
      .config_done_o(done), .mode_o(mode_o));
   fcmc_flash_model flash (.link_clk_i(link_clk), .flash_reset_n_i(prog_n), .timing_en_i(tmg),
      .addr_i(faddr), .hs_oe_o(fl_oe), .data_o(fdata));
   // ==========
   // Helpers
   task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task summarize;
      if (n_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   // stable mode, line held high afterwards
   task restart(input logic [2:0] m);
      @(negedge clk_i);
      mode = m;
      prog_n = 1'b0;
      repeat (6) @(negedge clk_i);
      chk("clear handshake", 1, hs_oe);
      prog_n = 1'b1;
      repeat (30) @(negedge clk_i);
   endtask : restart
   // ==========
   // Scenarios
   task t_flash;
      restart(3'h2);
      chk("timing enable", 1, tmg);
      chk("latched mode", 24'h2, mode_o);
      repeat (20) @(negedge clk_i);
      chk("address advanced", 1, faddr > 24'h0);
      fend = 1'b1;
      repeat (16) @(negedge clk_i);
      chk("load stopped", 0, tmg);
      chk("crc error handshake", 1, hs_oe);
      chk("not done", 0, done);
      fend = 1'b0;
   endtask : t_flash
   task t_jtag;
      restart(3'h5);
      chk("core busy", 1, busy);
      chk("no flash clock", 0, tmg);
      // line high, requests only through JTAG
      req = '{cmd: 8'h3C, data: 16'h1234, valid: 1'b1};
      @(negedge clk_i);
      req.valid = 1'b0;
      chk("answer valid", 1, resp.valid);
      chk("answer data", 24'h1208, resp.data);
      @(negedge clk_i);
      chk("answer pulse", 0, resp.valid);
      req.valid = 1'b1;
      prog_n = 1'b0;
      abort_seen = 1'b0;
      repeat (6)
      begin
         @(negedge clk_i);
         abort_seen = abort_seen | abort;
      end
      chk("abort seen", 1, abort_seen);
      chk("clear after abort", 1, hs_oe);
      req.valid = 1'b0;
      prog_n = 1'b1;
   endtask : t_jtag
   task t_idle;
      restart(3'h7);
      chk("idle no load", 0, tmg);
      chk("idle no core", 0, busy);
   endtask : t_idle
   initial
   begin
      repeat (16) @(negedge clk_i);
      nrst = 1'b1;
      t_flash();
      t_jtag();
      t_idle();
      summarize();
   end
   initial
   begin
      #200000;
      n_errors++;
      summarize();
   end
endmodule : flash_config_mode_control_tb
bind fcmc_top fcmc_top_chk chk_i (.clk_i(clk_i), .nrst_i(nrst_i),
   .flash_reset_n_i(flash_reset_n_i), .init_hs_o(init_hs_o), .init_hs_oe_o(init_hs_oe_o),
   .timing_en_o(timing_en_o), .frame_end_i(frame_end_i), .jtag_req_i(jtag_req_i),
   .jtag_resp_o(jtag_resp_o), .prog_busy_o(prog_busy_o), .prog_abort_o(prog_abort_o),
   .config_done_o(config_done_o), .mode_o(mode_o));
`default_nettype wire
